// file: qcp_counter.sv
`timescale 1ns/10ps
module qcp_counter (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic [qcp_pkg::IN_W-1:0] PINS,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ
);
	import qcp_pkg::*;
	logic enable;
	qcp_mode_type mode;
	logic signed [31:0] count_value;
	logic signed [31:0] upper_setpoint;
	logic signed [31:0] lower_setpoint;
	logic signed [31:0] overflow_limit;
	logic signed [31:0] underflow_limit;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic wr_pend;
	logic [7:0] wr_addr;
	qcp_act_type act;
	logic [IN_W-1:0] pins_sync;
	logic next_enable;
	qcp_mode_type next_mode;
	logic signed [31:0] next_count_value, next_upper, next_lower, next_over, next_under;
	logic [ST_W-1:0] next_status, next_mask, events;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_irq;
	logic addr_ok, rd_req;
	logic [7:0] rd_addr;
	logic ext_mode;

	qcp_decode u_decode (
		.CLOCK(CLOCK),
		.SRST(SRST),
		.pins(PINS),
		.mode(mode),
		.enable(enable),
		.act(act),
		.pins_sync(pins_sync)
	);

	always_comb begin
		addr_ok = HSEL && HREADY && HTRANS[1];
		rd_req = addr_ok && !HWRITE;
		rd_addr = HADDR[7:0];
		ext_mode = (mode == QCP_MODE_X1_EXT) || (mode == QCP_MODE_X4_EXT);
		next_wr_pend = addr_ok && HWRITE;
		next_wr_addr = HADDR[7:0];
		next_enable = enable;
		next_mode = mode;
		next_upper = upper_setpoint;
		next_lower = lower_setpoint;
		next_over = overflow_limit;
		next_under = underflow_limit;
		next_mask = mask;
		events = '0;
		next_count_value = count_value;
		unique case (act)
			QCP_UP: begin
				if (count_value == overflow_limit) begin
					next_count_value = underflow_limit;
					events[ST_OVER] = 1'b1;
				end else begin
					next_count_value = count_value + 32'sh1;
				end
			end
			QCP_DOWN: begin
				if (count_value == underflow_limit) begin
					next_count_value = overflow_limit;
					events[ST_UNDER] = 1'b1;
				end else begin
					next_count_value = count_value - 32'sh1;
				end
			end
			QCP_CLEAR: next_count_value = '0;
			QCP_HOLD: next_count_value = count_value;
		endcase
		if (act == QCP_UP && next_count_value == upper_setpoint) events[ST_UPPER] = 1'b1;
		if (act == QCP_DOWN && next_count_value == lower_setpoint) events[ST_LOWER] = 1'b1;
		if (wr_pend) begin
			unique case (wr_addr)
				OFF_CTRL: begin
					next_enable = HWDATA[CTRL_EN];
					next_mode = qcp_mode_type'(HWDATA[CTRL_MODE_LO +: 2]);
				end
				OFF_COUNT: next_count_value = HWDATA;
				OFF_UPPER: begin
					next_upper = HWDATA;
					if ($signed(HWDATA) > overflow_limit) events[ST_ERR] = 1'b1;
				end
				OFF_LOWER: begin
					next_lower = HWDATA;
					if ($signed(HWDATA) < underflow_limit) events[ST_ERR] = 1'b1;
				end
				OFF_OVER: next_over = HWDATA;
				OFF_UNDER: next_under = HWDATA;
				OFF_MASK: next_mask = HWDATA[ST_W-1:0];
				default: ;
			endcase
		end
		next_status = status;
		if (wr_pend && wr_addr == OFF_STATUS) next_status = status & ~HWDATA[ST_W-1:0];
		// set beats clear in the same cycle
		next_status = next_status | events;
		next_irq = |(next_status & next_mask);
		next_hrdata = '0;
		if (rd_req) begin
			unique case (rd_addr)
				OFF_CTRL: next_hrdata = {29'h0, 2'(next_mode), next_enable};
				OFF_COUNT: next_hrdata = next_count_value;
				OFF_UPPER: next_hrdata = next_upper;
				OFF_LOWER: next_hrdata = next_lower;
				OFF_OVER: next_hrdata = next_over;
				OFF_UNDER: next_hrdata = next_under;
				OFF_STATUS: next_hrdata = {27'h0, next_status};
				OFF_MASK: next_hrdata = {27'h0, next_mask};
				OFF_INPUTS: next_hrdata = {20'h0, pins_sync};
				default: next_hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			enable <= 1'b0;
			mode <= QCP_MODE_X1;
			count_value <= '0;
			upper_setpoint <= UPPER_RESET;
			lower_setpoint <= LOWER_RESET;
			overflow_limit <= OVER_RESET;
			underflow_limit <= UNDER_RESET;
			status <= '0;
			mask <= '0;
			wr_pend <= 1'b0;
			wr_addr <= '0;
			HRDATA <= '0;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			enable <= next_enable;
			mode <= next_mode;
			count_value <= next_count_value;
			upper_setpoint <= next_upper;
			lower_setpoint <= next_lower;
			overflow_limit <= next_over;
			underflow_limit <= next_under;
			status <= next_status;
			mask <= next_mask;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			HRDATA <= next_hrdata;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			IRQ <= next_irq;
		end
	end

	sequence s_up_act;
		act == QCP_UP && count_value != overflow_limit && !(wr_pend && wr_addr == OFF_COUNT);
	endsequence
	sequence s_down_act;
		act == QCP_DOWN && count_value != underflow_limit && !(wr_pend && wr_addr == OFF_COUNT);
	endsequence

	a_count_up: assert property (@(posedge CLOCK) disable iff (SRST)
		s_up_act |=> count_value == $past(count_value) + 32'sh1) else $error("count up missed");
	a_count_down: assert property (@(posedge CLOCK) disable iff (SRST)
		s_down_act |=> count_value == $past(count_value) - 32'sh1) else $error("count down missed");
	a_clear_zero: assert property (@(posedge CLOCK) disable iff (SRST)
		act == QCP_CLEAR && !wr_pend |=> count_value == 0) else $error("clear missed");
	a_hold_value: assert property (@(posedge CLOCK) disable iff (SRST)
		act == QCP_HOLD && !wr_pend |=> $stable(count_value)) else $error("count moved on hold");
	a_over_wrap: assert property (@(posedge CLOCK) disable iff (SRST)
		act == QCP_UP && count_value == overflow_limit && !wr_pend
		|=> count_value == $past(underflow_limit) && status[ST_OVER]) else $error("overflow wrap wrong");
	a_under_wrap: assert property (@(posedge CLOCK) disable iff (SRST)
		act == QCP_DOWN && count_value == underflow_limit && !wr_pend
		|=> count_value == $past(overflow_limit) && status[ST_UNDER]) else $error("underflow wrap wrong");
	a_upper_err: assert property (@(posedge CLOCK) disable iff (SRST)
		wr_pend && wr_addr == OFF_UPPER && $signed(HWDATA) > overflow_limit |=> status[ST_ERR])
		else $error("upper error missed");
	a_lower_err: assert property (@(posedge CLOCK) disable iff (SRST)
		wr_pend && wr_addr == OFF_LOWER && $signed(HWDATA) < underflow_limit |=> status[ST_ERR])
		else $error("lower error missed");
	a_upper_event: assert property (@(posedge CLOCK) disable iff (SRST)
		s_up_act ##0 (count_value + 32'sh1 == upper_setpoint) |=> status[ST_UPPER])
		else $error("upper event missed");
	a_lower_event: assert property (@(posedge CLOCK) disable iff (SRST)
		s_down_act ##0 (count_value - 32'sh1 == lower_setpoint) |=> status[ST_LOWER])
		else $error("lower event missed");
	a_irq_level: assert property (@(posedge CLOCK) disable iff (SRST)
		##1 IRQ == |(status & mask)) else $error("irq level wrong");
	a_hold_input: assert property (@(posedge CLOCK) disable iff (SRST)
		ext_mode && pins_sync[PIN_HOLD] && !pins_sync[PIN_RST] |=> act == QCP_HOLD)
		else $error("hold input ignored");
	a_steady_phase: assert property (@(posedge CLOCK) disable iff (SRST)
		(mode == QCP_MODE_X1 || mode == QCP_MODE_X1_EXT) && $stable(pins_sync[PIN_A])
		|=> act != QCP_UP && act != QCP_DOWN) else $error("count without phase edge");
	a_enable_off: assert property (@(posedge CLOCK) disable iff (SRST)
		!enable |=> act != QCP_UP && act != QCP_DOWN) else $error("counted while disabled");
	a_index_clear: assert property (@(posedge CLOCK) disable iff (SRST)
		ext_mode && pins_sync[PIN_RST] && !pins_sync[PIN_A] && !pins_sync[PIN_B] |=> act == QCP_CLEAR)
		else $error("index reset ignored");
	a_count_read: assert property (@(posedge CLOCK) disable iff (SRST)
		rd_req && rd_addr == OFF_COUNT |=> HRDATA == count_value) else $error("count read stale");
	a_inputs_read: assert property (@(posedge CLOCK) disable iff (SRST)
		rd_req && rd_addr == OFF_INPUTS |=> HRDATA == {20'h0, $past(pins_sync)})
		else $error("inputs read wrong");
endmodule

// file: qcp_pkg.sv
// How it works
// - two-phase mode with reset/hold: A rising with B low counts up.
// - same mode: A falling with B low counts down.
// - index reset high with both phases low clears the count to zero.
// - A,B,reset,hold on inputs 0..3; steady level, hold or enable off holds.
// - four-edge mode: an A or B edge counts up or down by phase; only the A edge counts if both move in one clock.
// - four-edge mode holds with no edge or with count enable off.
// - four-edge with external inputs: reset clears at phases low; hold freezes.
// - the readable count always shows the live count.
// - reaching the upper setpoint raises an event.
// - upper setpoint above the overflow limit flags a counter error.
// - reaching the lower setpoint raises an event.
// - lower setpoint below the underflow limit flags a counter error.
// - inputs 0..11 stay readable whatever the mode.
// - increment past overflow limit raises event, reloads underflow limit.
// - decrement past underflow limit raises event, reloads overflow limit.
package qcp_pkg;
	localparam int IN_W = 12;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_UPPER = 8'h08;
	localparam logic [7:0] OFF_LOWER = 8'h0C;
	localparam logic [7:0] OFF_OVER = 8'h10;
	localparam logic [7:0] OFF_UNDER = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1C;
	localparam logic [7:0] OFF_INPUTS = 8'h20;
	localparam int CTRL_EN = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int ST_UPPER = 0;
	localparam int ST_LOWER = 1;
	localparam int ST_OVER = 2;
	localparam int ST_UNDER = 3;
	localparam int ST_ERR = 4;
	localparam int ST_W = 5;
	localparam int PIN_A = 0;
	localparam int PIN_B = 1;
	localparam int PIN_RST = 2;
	localparam int PIN_HOLD = 3;
	localparam logic [31:0] OVER_RESET = 32'h7FFFFFFF;
	localparam logic [31:0] UNDER_RESET = 32'h80000000;
	localparam logic [31:0] UPPER_RESET = 32'h7FFFFFFF;
	localparam logic [31:0] LOWER_RESET = 32'h80000000;
	typedef enum logic [1:0] {
		QCP_MODE_X1 = 2'h0,
		QCP_MODE_X1_EXT = 2'h1,
		QCP_MODE_X4 = 2'h2,
		QCP_MODE_X4_EXT = 2'h3
	} qcp_mode_type;
	typedef enum logic [1:0] {QCP_HOLD, QCP_UP, QCP_DOWN, QCP_CLEAR} qcp_act_type;
endpackage

// file: qcp_decode.sv
`timescale 1ns/10ps
module qcp_decode (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic [qcp_pkg::IN_W-1:0] pins,
	input wire qcp_pkg::qcp_mode_type mode,
	input wire logic enable,
	output qcp_pkg::qcp_act_type act,
	output logic [qcp_pkg::IN_W-1:0] pins_sync
);
	import qcp_pkg::*;
	logic [IN_W-1:0] meta;
	logic [IN_W-1:0] prev;
	logic a_rise, a_fall, b_rise, b_fall, a, b, rst_in, hold_in, ext;
	qcp_act_type next_act;

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			meta <= '0;
			pins_sync <= '0;
			prev <= '0;
			act <= QCP_HOLD;
		end else begin
			meta <= pins;
			pins_sync <= meta;
			prev <= pins_sync;
			act <= next_act;
		end
	end

	always_comb begin
		a = pins_sync[PIN_A];
		b = pins_sync[PIN_B];
		rst_in = pins_sync[PIN_RST];
		hold_in = pins_sync[PIN_HOLD];
		a_rise = a & ~prev[PIN_A];
		a_fall = ~a & prev[PIN_A];
		b_rise = b & ~prev[PIN_B];
		b_fall = ~b & prev[PIN_B];
		ext = (mode == QCP_MODE_X1_EXT) || (mode == QCP_MODE_X4_EXT);
		next_act = QCP_HOLD;
		if (ext && rst_in) begin
			// reset only acts with both phases low; otherwise it just blocks counting
			if (!a && !b) next_act = QCP_CLEAR;
		end else if (ext && hold_in) begin
			next_act = QCP_HOLD;
		end else if (enable) begin
			if (mode == QCP_MODE_X4 || mode == QCP_MODE_X4_EXT) begin
				// one action per clock: A edges win when both phases move at once
				if (a_rise) next_act = b ? QCP_DOWN : QCP_UP;
				else if (a_fall) next_act = b ? QCP_UP : QCP_DOWN;
				else if (b_rise) next_act = a ? QCP_UP : QCP_DOWN;
				else if (b_fall) next_act = a ? QCP_DOWN : QCP_UP;
			end else if (!b) begin
				if (a_rise) next_act = QCP_UP;
				else if (a_fall) next_act = QCP_DOWN;
			end
		end
	end
endmodule

// file: qcp_encoder.sv
`timescale 1ns/10ps
module qcp_encoder (
	input wire logic clock,
	output logic [11:0] pins
);
	initial pins = 12'h000;
	// the decoder needs every level held at least 1 clock; the count follows 4 clocks after the pin change
	task automatic drive(input logic [11:0] v, input int gap);
		@(posedge clock);
		pins <= v;
		repeat (gap) @(posedge clock);
	endtask
endmodule

// file: qcp_counter_tb.sv
`timescale 1ns/10ps
module qcp_counter_tb;
	import qcp_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, cnt, rd;
	logic hready, hresp, irq, b;
	logic [11:0] pins;
	int mismatches = 0;
	int compares = 0;
	logic [39:0] rst_tab [9] = '{{OFF_CTRL, 32'h0}, {OFF_COUNT, 32'h0}, {OFF_UPPER, UPPER_RESET},
		{OFF_LOWER, LOWER_RESET}, {OFF_OVER, OVER_RESET}, {OFF_UNDER, UNDER_RESET},
		{OFF_STATUS, 32'h0}, {OFF_MASK, 32'h0}, {8'h40, 32'h0}};
	always #2.5 clock = ~clock;
	qcp_encoder i_qcp_encoder (.clock(clock), .pins(pins));
	qcp_counter i_qcp_counter (.CLOCK(clock), .SRST(srst), .PINS(pins), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, rd, exp);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic st(input logic [31:0] e);
		expect_reg("status", OFF_STATUS, e);
		bus(1'b1, OFF_STATUS, 32'h1F);
	endtask
	// flips one phase, spare terminals random, and tracks the count
	task automatic phase(input logic wb, input logic [31:0] d);
		logic [11:0] v;
		v = pins;
		v[wb] = ~v[wb];
		v[11:4] = 8'($urandom);
		i_qcp_encoder.drive(v, 6 + $urandom_range(0, 3));
		cnt = cnt + d;
	endtask
	function automatic logic [31:0] x4_step(input logic [11:0] p, input logic wb);
		if (!wb)
			return (!p[0] != p[1]) ? 32'h1 : 32'hFFFFFFFF;
		return ((!p[1]) == p[0]) ? 32'h1 : 32'hFFFFFFFF;
	endfunction
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100us;
		mismatches++;
		end_of_test();
	end
	initial begin
		rd = $urandom(32'hDFB3);
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		foreach (rst_tab[i]) expect_reg("reset", rst_tab[i][39:32], rst_tab[i][31:0]);
		$display("reset test done");
		bus(1'b1, OFF_CTRL, 32'h5);
		cnt = $urandom & 32'h0FFFFFFF;
		bus(1'b1, OFF_COUNT, cnt);
		for (int i = 0; i < 40; i++) begin
			b = 1'($urandom);
			phase(b, x4_step(pins, b));
			expect_reg("count", OFF_COUNT, cnt);
			expect_reg("inputs", OFF_INPUTS, {20'h0, pins});
		end
		bus(1'b1, OFF_CTRL, 32'h4);
		phase(1'b0, 32'h0);
		expect_reg("disabled", OFF_COUNT, cnt);
		i_qcp_encoder.drive(12'h000, 6);
		$display("x4 test done");
		bus(1'b1, OFF_CTRL, 32'h1);
		cnt = 32'h200;
		bus(1'b1, OFF_COUNT, cnt);
		phase(1'b0, 32'h1);
		expect_reg("x1 up", OFF_COUNT, cnt);
		// plain two-phase mode ignores the index reset, so this is just a down count
		i_qcp_encoder.drive(12'h004, 6);
		cnt = cnt - 32'h1;
		expect_reg("x1 down", OFF_COUNT, cnt);
		i_qcp_encoder.drive(12'h000, 6);
		bus(1'b1, OFF_CTRL, 32'h3);
		cnt = 32'h100;
		bus(1'b1, OFF_COUNT, cnt);
		phase(1'b0, 32'h1);
		expect_reg("up", OFF_COUNT, cnt);
		phase(1'b0, 32'hFFFFFFFF);
		expect_reg("down", OFF_COUNT, cnt);
		i_qcp_encoder.drive(12'h008, 6);
		phase(1'b0, 32'h0);
		expect_reg("hold", OFF_COUNT, cnt);
		i_qcp_encoder.drive(12'h001, 6);
		i_qcp_encoder.drive(12'h000, 6);
		i_qcp_encoder.drive(12'h004, 6);
		expect_reg("clear", OFF_COUNT, 32'h0);
		bus(1'b1, OFF_CTRL, 32'h7);
		// drop the index reset first: left high it clears the loaded value
		i_qcp_encoder.drive(12'h008, 6);
		cnt = 32'h55;
		bus(1'b1, OFF_COUNT, cnt);
		phase(1'b1, 32'h0);
		expect_reg("x4 hold", OFF_COUNT, cnt);
		i_qcp_encoder.drive(12'h006, 6);
		i_qcp_encoder.drive(12'h004, 6);
		expect_reg("x4 clear", OFF_COUNT, 32'h0);
		i_qcp_encoder.drive(12'h000, 6);
		$display("external input test done");
		bus(1'b1, OFF_CTRL, 32'h5);
		bus(1'b1, OFF_STATUS, 32'h1F);
		bus(1'b1, OFF_MASK, 32'h1F);
		bus(1'b1, OFF_UPPER, 32'h10);
		bus(1'b1, OFF_LOWER, 32'hE);
		cnt = 32'hF;
		bus(1'b1, OFF_COUNT, cnt);
		phase(1'b0, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		st(32'h1);
		// irq drops on the edge that ends the clearing write
		@(posedge clock);
		check("irq clear", {31'h0, irq}, 32'h0);
		phase(1'b0, 32'hFFFFFFFF);
		phase(1'b1, 32'hFFFFFFFF);
		st(32'h2);
		bus(1'b1, OFF_OVER, 32'h20);
		bus(1'b1, OFF_COUNT, 32'h20);
		phase(1'b1, 32'h0);
		expect_reg("wrap up", OFF_COUNT, UNDER_RESET);
		st(32'h4);
		phase(1'b1, 32'h0);
		expect_reg("wrap down", OFF_COUNT, 32'h20);
		st(32'h8);
		bus(1'b1, OFF_UPPER, 32'h21);
		st(32'h10);
		bus(1'b1, OFF_UPPER, 32'h20);
		st(32'h0);
		bus(1'b1, OFF_UNDER, 32'hFFFFFFF0);
		bus(1'b1, OFF_LOWER, 32'hFFFFFFEF);
		st(32'h10);
		bus(1'b1, OFF_LOWER, 32'hFFFFFFF8);
		st(32'h0);
		$display("event test done");
		end_of_test();
	end
endmodule
